// File: dv/wdtc_chk.sv
// assertion checker for the watchdog timer control block
`timescale 1ns/10ps
`default_nettype none
module wdtc_chk #(
  parameter int OSC_DIV = 2
) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // register bus
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // system side
  input wire logic        i_reset_cause_flag,
  input wire logic        i_always_on_fuse,
  input wire logic        i_global_irq_enable,
  input wire logic        i_irq_vector_ack,
  input wire logic        o_timeout_irq,
  input wire logic        o_system_reset_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // request in progress and accepted reads
  wire req = i_avs_read | i_avs_write;
  sequence s_ctrl_rd; i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h0; endsequence
  sequence s_stat_rd; i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h4; endsequence
  one_wait_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait state");
  idle_nowait_a: assert property (!req |-> !o_avs_waitrequest) else $error("wait while idle");
  gie_gate_a: assert property (!i_global_irq_enable |-> !o_timeout_irq)
    else $error("irq without global enable");
  rst_pulse_a: assert property (o_system_reset_req |=> !o_system_reset_req)
    else $error("reset request too long");
  fuse_lock_a: assert property (s_ctrl_rd |-> !i_always_on_fuse ||
    (o_avs_readdata[3] && !o_avs_readdata[6])) else $error("fuse lock broken");
  cause_force_a: assert property (s_ctrl_rd ##0 i_reset_cause_flag |-> o_avs_readdata[3])
    else $error("cause flag not forcing");
  stat_bits_a: assert property (s_stat_rd |->
    o_avs_readdata[2:1] == {i_reset_cause_flag, i_always_on_fuse}) else $error("status bits");
  ack_clr_a: assert property (i_irq_vector_ack && o_timeout_irq |=> !o_timeout_irq)
    else $error("ack left irq");
  fuse_irq_a: assert property (i_always_on_fuse |-> !o_timeout_irq)
    else $error("irq under fuse");
  rd_reset_a: assert property ($rose(i_rst_n) |-> o_avs_readdata == 32'h0)
    else $error("readdata after reset");
endmodule // wdtc_chk
bind wdtc_top wdtc_chk #(.OSC_DIV(OSC_DIV)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_reset_cause_flag(i_reset_cause_flag), .i_always_on_fuse(i_always_on_fuse),
  .i_global_irq_enable(i_global_irq_enable), .i_irq_vector_ack(i_irq_vector_ack),
  .o_timeout_irq(o_timeout_irq), .o_system_reset_req(o_system_reset_req));
`default_nettype wire

// File: dv/wdtc_top_bench.sv
// self-checking bench for the watchdog timer control block
`timescale 1ns/10ps
`default_nettype none
module wdtc_top_bench;
  logic        clk, rst_n, rd, wr, fuse, cause, gie, ack, rs, wreq, irq, srst;
  logic [3:0]  adr;
  logic [31:0] wd, rdat;
  logic [7:0]  d;
  int          miscompares, compares, first_irq, nrst;
  wdtc_top #(.OSC_DIV(2)) u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_reset_cause_flag(cause),
    .i_always_on_fuse(fuse), .i_global_irq_enable(gie), .i_irq_vector_ack(ack),
    .i_watchdog_restart(rs), .o_timeout_irq(irq), .o_system_reset_req(srst));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) begin
      miscompares++;
      final_report();
    end
    d = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(d, exp);
  endtask
  // one-cycle pulse on vector ack or restart
  task automatic pulse(input logic vec);
    @(posedge clk);
    ack <= vec;
    rs <= ~vec;
    @(posedge clk);
    ack <= 1'b0;
    rs <= 1'b0;
  endtask
  // run n cycles noting first irq and reset pulses
  task automatic run(input int n);
    first_irq = -1;
    nrst = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (irq === 1'b1 && first_irq < 0) first_irq = i;
      if (srst === 1'b1) nrst++;
    end
  endtask
  // main sequence
  initial begin
    {rst_n, rd, wr, fuse, cause, ack, rs} = '0;
    gie = 1'b1;
    adr = 4'h0;
    wd = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(4'h0, 8'h00);
    rchk(4'h8, 8'h00);
    bus(1'b1, 4'h0, 8'h40);
    run(3000);
    pulse(1'b0);
    run(4200);
    chk({7'h0, first_irq > 4080 && first_irq < 4110}, 8'h01);
    chk({7'h0, nrst == 0}, 8'h01);
    rchk(4'h0, 8'hc0);
    gie <= 1'b0;
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    gie <= 1'b1;
    @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, 4'h0, 8'h40);
    rchk(4'h0, 8'hc0);
    bus(1'b1, 4'h0, 8'hc0);
    rchk(4'h0, 8'h40);
    bus(1'b1, 4'h0, 8'h48);
    pulse(1'b0);
    run(4200);
    chk({6'h0, first_irq >= 0, nrst == 0}, 8'h03);
    run(4200);
    chk({7'h0, nrst == 1}, 8'h01);
    pulse(1'b1);
    rchk(4'h0, 8'h08);
    bus(1'b1, 4'h0, 8'h18);
    rchk(4'h0, 8'h18);
    repeat (4) @(posedge clk);
    rchk(4'h0, 8'h08);
    bus(1'b1, 4'h0, 8'h01);
    rchk(4'h0, 8'h08);
    pulse(1'b0);
    bus(1'b1, 4'h0, 8'h18);
    bus(1'b1, 4'h0, 8'h01);
    rchk(4'h0, 8'h01);
    cause <= 1'b1;
    rchk(4'h0, 8'h09);
    cause <= 1'b0;
    run(4500);
    chk({6'h0, first_irq < 0, nrst == 0}, 8'h03);
    bus(1'b1, 4'h0, 8'h41);
    pulse(1'b0);
    run(8300);
    chk({7'h0, first_irq > 8176 && first_irq < 8210}, 8'h01);
    fuse <= 1'b1;
    bus(1'b0, 4'h0, 8'h00);
    chk(d & 8'h48, 8'h08);
    bus(1'b0, 4'h4, 8'h00);
    chk(d & 8'h06, 8'h02);
    final_report();
  end
endmodule // wdtc_top_bench
`default_nettype wire

// File: verilog/wdtc_counter.sv
// watchdog counter with selectable time-out length
`timescale 1ns/10ps
`default_nettype none
module wdtc_counter #(
  parameter int CNT_W = wdtc_pkg::WDTC_CNT_W
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic       i_restart,
  input  wire logic [3:0] i_sel,
  // event
  output logic            o_timeout
);
  import wdtc_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit;
  // last count before wrap: 2048 << sel, minus one
  assign limit     = (CNT_W'(1) << (WDTC_BASE_LOG2 + int'(i_sel))) - CNT_W'(1);
  assign o_timeout = i_run && i_tick && !i_restart && (cnt_q >= limit);
  // restart clears, stop holds at zero
  assign cnt_d = (i_restart || !i_run || o_timeout) ? '0 :
                 i_tick ? cnt_q + CNT_W'(1) : cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cnt_q <= '0;
    else          cnt_q <= cnt_d;
  end
endmodule // wdtc_counter
`default_nettype wire

// File: verilog/wdtc_osc_tick.sv
// tick generator standing in for the separate watchdog oscillator
`timescale 1ns/10ps
`default_nettype none
module wdtc_osc_tick #(
  parameter int DIV = wdtc_pkg::WDTC_SYS_HZ / wdtc_pkg::WDTC_OSC_HZ
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // tick out
  output logic      o_tick
);
  import wdtc_pkg::*;
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  // free running divider, one pulse per oscillator period
  assign o_tick = (cnt_q == W'(DIV - 1));
  assign cnt_d  = o_tick ? '0 : cnt_q + W'(1);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cnt_q <= '0;
    else          cnt_q <= cnt_d;
  end
endmodule // wdtc_osc_tick
`default_nettype wire

// File: verilog/wdtc_pkg.sv
// package of constants for the watchdog timer control block
package wdtc_pkg;
  // register map (byte addresses, one word per register)
  localparam logic [3:0] WDTC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] WDTC_ADDR_STATUS = 4'h4;
  // control/status field positions
  localparam int WDTC_BIT_IRQ_FLAG   = 7;
  localparam int WDTC_BIT_IRQ_EN     = 6;
  localparam int WDTC_BIT_SEL3       = 5;
  localparam int WDTC_BIT_CHG_EN     = 4;
  localparam int WDTC_BIT_RST_EN     = 3;
  localparam int WDTC_SEL_LO_MSB     = 2;
  // reset values
  localparam logic [7:0] WDTC_CTRL_RESET = 8'h00;
  // timing
  localparam int WDTC_CHG_WINDOW_CYC = 4;
  localparam int WDTC_BASE_LOG2      = 11;
  localparam logic [3:0] WDTC_SEL_MAX = 4'h9;
  localparam int WDTC_CNT_W          = 21;
  // watchdog oscillator and system clock rates
  localparam int WDTC_OSC_HZ         = 128000;
  localparam int WDTC_SYS_HZ         = 200000000;
  // mode encoding
  typedef enum logic [1:0] {
    WDTC_STOPPED = 2'b00,
    WDTC_IRQ     = 2'b01,
    WDTC_RESET   = 2'b10,
    WDTC_BOTH    = 2'b11
  } wdtc_mode_t;
endpackage

// File: verilog/wdtc_top.sv
// watchdog timer control: control/status register, modes and time-out actions
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module wdtc_top #(
  parameter int OSC_DIV = wdtc_pkg::WDTC_SYS_HZ / wdtc_pkg::WDTC_OSC_HZ
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // system inputs
  input  wire logic        i_reset_cause_flag,
  input  wire logic        i_always_on_fuse,
  input  wire logic        i_global_irq_enable,
  input  wire logic        i_irq_vector_ack,
  input  wire logic        i_watchdog_restart,
  // system outputs
  output logic             o_timeout_irq,
  output logic             o_system_reset_req
);
  import wdtc_pkg::*;

  // register state
  logic       irq_flag_q,   irq_flag_d;
  logic       irq_en_q,     irq_en_d;
  logic       rst_en_q,     rst_en_d;
  logic       chg_en_q,     chg_en_d;
  logic [3:0] sel_q,        sel_d;
  logic [2:0] chg_cnt_q,    chg_cnt_d;
  logic       ack_q;
  logic [31:0] rdata_q,     rdata_d;
  logic       rst_req_q,    rst_req_d;

  // bus decode
  logic       acc;
  logic       wr_ctrl;
  logic       rd_hit;
  logic [7:0] wd;
  assign acc     = (i_avs_read || i_avs_write) && !ack_q;
  // write lands at the edge where waitrequest is low (second cycle)
  assign wr_ctrl = i_avs_write && ack_q && (i_avs_address == WDTC_ADDR_CTRL)
                   && i_avs_byteenable[0];
  assign rd_hit  = acc && i_avs_read;
  assign wd      = i_avs_writedata[7:0];
  // one wait state, answer in second cycle
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata    = rdata_q;

  // effective enables after fuse and reset-cause overrides
  logic eff_rst_en;
  logic eff_irq_en;
  wdtc_mode_t mode;
  assign eff_rst_en = i_always_on_fuse || i_reset_cause_flag || rst_en_q;
  assign eff_irq_en = !i_always_on_fuse && irq_en_q;
  assign mode       = wdtc_mode_t'({eff_rst_en, eff_irq_en});
  logic run;
  assign run = (mode != WDTC_STOPPED);

  // control register read image
  logic [7:0] ctrl_img;
  assign ctrl_img = {irq_flag_q, eff_irq_en, sel_q[3], chg_en_q,
                     eff_rst_en, sel_q[2:0]};

  // time-out machinery
  logic tick;
  logic timeout;
  wdtc_osc_tick #(.DIV(OSC_DIV)) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );
  wdtc_counter u_cnt (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (run),
    .i_tick    (tick),
    .i_restart (i_watchdog_restart),
    .i_sel     (sel_q),
    .o_timeout (timeout)
  );

  // protected write acceptance
  logic prot_ok;
  logic new_rst_en;
  logic [3:0] new_sel;
  assign prot_ok    = chg_en_q;
  assign new_sel    = {wd[WDTC_BIT_SEL3], wd[WDTC_SEL_LO_MSB:0]};
  assign new_rst_en = wd[WDTC_BIT_RST_EN] ? 1'b1 :
                      (prot_ok ? 1'b0 : rst_en_q);

  // time-out actions per mode
  logic set_flag;
  logic do_reset;
  logic vec_clr;
  assign set_flag = timeout && (mode == WDTC_IRQ ||
                    (mode == WDTC_BOTH && !irq_flag_q));
  assign do_reset = timeout && (mode == WDTC_RESET ||
                    (mode == WDTC_BOTH && irq_flag_q));
  assign vec_clr  = i_irq_vector_ack && irq_flag_q;

  // next-state logic
  always_comb begin
    irq_flag_d = irq_flag_q;
    irq_en_d   = irq_en_q;
    rst_en_d   = rst_en_q;
    chg_en_d   = chg_en_q;
    sel_d      = sel_q;
    chg_cnt_d  = chg_cnt_q;
    rdata_d    = rdata_q;
    rst_req_d  = do_reset;
    // change enable window counts up, then closes
    if (chg_en_q) begin
      if (chg_cnt_q == 3'(WDTC_CHG_WINDOW_CYC - 1)) begin
        chg_en_d = 1'b0;
      end else begin
        chg_cnt_d = chg_cnt_q + 3'h1;
      end
    end
    if (wr_ctrl) begin
      if (wd[WDTC_BIT_IRQ_FLAG]) begin
        irq_flag_d = 1'b0;
      end
      irq_en_d = wd[WDTC_BIT_IRQ_EN];
      // clearing reset enable is blocked while the cause flag stands
      rst_en_d = new_rst_en;
      if (i_reset_cause_flag) begin
        rst_en_d = 1'b1;
      end
      if (prot_ok) begin
        sel_d = new_sel;
      end
      if (wd[WDTC_BIT_CHG_EN] && !chg_en_q) begin
        chg_en_d  = 1'b1;
        chg_cnt_d = 3'h0;
      end else if (!wd[WDTC_BIT_CHG_EN]) begin
        chg_en_d = 1'b0;
      end
    end
    // vector execution clears the flag; combined mode also disarms
    if (vec_clr) begin
      irq_flag_d = 1'b0;
      if (mode == WDTC_BOTH) begin
        irq_en_d = 1'b0;
      end
    end
    // hardware set wins over clear
    if (set_flag) begin
      irq_flag_d = 1'b1;
    end
    // read data
    if (rd_hit) begin
      case (i_avs_address)
        WDTC_ADDR_CTRL:   rdata_d = {24'h000000, ctrl_img};
        WDTC_ADDR_STATUS: rdata_d = {28'h0000000, run, i_reset_cause_flag,
                                     i_always_on_fuse, irq_flag_q};
        default:          rdata_d = 32'h00000000;
      endcase
    end
  end

  // interrupt request gating
  assign o_timeout_irq      = irq_flag_q && eff_irq_en && i_global_irq_enable;
  assign o_system_reset_req = rst_req_q;

  // register updates
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_flag_q <= WDTC_CTRL_RESET[WDTC_BIT_IRQ_FLAG];
      irq_en_q   <= WDTC_CTRL_RESET[WDTC_BIT_IRQ_EN];
      rst_en_q   <= WDTC_CTRL_RESET[WDTC_BIT_RST_EN];
      chg_en_q   <= WDTC_CTRL_RESET[WDTC_BIT_CHG_EN];
      sel_q      <= 4'h0;
      chg_cnt_q  <= 3'h0;
      ack_q      <= 1'b0;
      rdata_q    <= 32'h00000000;
      rst_req_q  <= 1'b0;
    end else begin
      irq_flag_q <= irq_flag_d;
      irq_en_q   <= irq_en_d;
      rst_en_q   <= rst_en_d;
      chg_en_q   <= chg_en_d;
      sel_q      <= sel_d;
      chg_cnt_q  <= chg_cnt_d;
      ack_q      <= acc;
      rdata_q    <= rdata_d;
      rst_req_q  <= rst_req_d;
    end
  end
endmodule // wdtc_top
`default_nettype wire
